// ### core/mrar_top.sv
// Result and diagnostic/alert register bank of a current and power monitor
`timescale 1ns/1ps
// Operation
// - Shunt result, signed 16 bits, at 4h
// - Bus voltage result, 16 bits, at 5h
// - Die temperature in bits 15 to 4 at 6h
// - Reserved bits read back as zero
// - Signed current result at 7h
// - Unsigned 24-bit power result at 8h
// - Diag resets 0001h, results reset zero
// - Transparent mode: alert follows fault condition
// - Latched mode: alert holds until a diag read while the fault is gone
// - Ready-to-alert routes done flag to alert
// - Select raw or averaged compare source
// - Alert polarity: low or high, open-drain
// - Overflow flag set on arithmetic overflow
// - Overflow cleared only by new conversion
// - Done flag set; latched clears on read/trigger
// - Results update after averaging completes
module mrar_top
    import mrar_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic [7:0] I_RD_ADDR,
    input wire logic I_RD_STB,
    output logic [23:0] O_RD_DATA,
    output logic O_RD_VALID,
    input wire logic I_WR_STB,
    input wire logic [15:0] I_WR_DATA,
    input wire logic I_CONV_START,
    input wire logic I_AVG_DONE,
    input wire logic I_SAMPLE_DONE,
    input wire logic I_SHUNT_UPD,
    input wire logic [15:0] I_SHUNT_VAL,
    input wire logic I_BUS_UPD,
    input wire logic [15:0] I_BUS_VAL,
    input wire logic I_TEMP_UPD,
    input wire logic [11:0] I_TEMP_VAL,
    input wire logic I_CALC_UPD,
    input wire logic [15:0] I_CURR_VAL,
    input wire logic [23:0] I_POWER_VAL,
    input wire logic I_MATH_OVF,
    input wire logic I_FAULT_RAW,
    input wire logic I_FAULT_AVG,
    input wire logic I_MEM_OK,
    input wire logic I_ALERT_PIN,
    output logic O_ALERT_OUT,
    output logic O_ALERT_OE,
    output logic O_ALERT_LEVEL
);
    logic [15:0] shunt_q;
    logic [15:0] bus_q;
    logic [11:0] temp_q;
    logic [15:0] curr_q;
    logic [23:0] power_q;
    logic [3:0] cfg_q;
    logic [3:0] cfg_d;
    logic ovf_q;
    logic ovf_d;
    logic done_q;
    logic done_d;
    logic [23:0] rd_data_d;
    logic alert_level;
    mrar_alert_t alert_q;
    mrar_alert_t alert_d;

    // Result register widths
    localparam int SHUNT_W = 16;
    localparam int BUS_W = 16;
    localparam int TEMP_W = 12;
    localparam int CURR_W = 16;
    localparam int POWER_W = 24;

    // Register index to one-hot select
    function automatic logic [5:0] reg_select(input logic [7:0] addr);
        logic [5:0] sel;
        sel = 6'h00;
        sel[0] = (addr == ADDR_SHUNT);
        sel[1] = (addr == ADDR_BUS);
        sel[2] = (addr == ADDR_TEMP);
        sel[3] = (addr == ADDR_CURR);
        sel[4] = (addr == ADDR_POWER);
        sel[5] = (addr == ADDR_DIAG);
        return sel;
    endfunction

    // Zero-extend a 16-bit word onto the read bus
    function automatic logic [23:0] pad_word(input logic [15:0] value);
        return {8'h00, value};
    endfunction

    // Read address decode
    wire [5:0] rd_sel = reg_select(I_RD_ADDR);
    wire sel_shunt = rd_sel[0];
    wire sel_bus = rd_sel[1];
    wire sel_temp = rd_sel[2];
    wire sel_curr = rd_sel[3];
    wire sel_power = rd_sel[4];
    wire sel_diag = rd_sel[5];
    wire diag_read = I_RD_STB && sel_diag;
    wire diag_write = I_WR_STB;

    // Configuration fields
    wire latch_en = cfg_q[3];
    wire ready_alert = cfg_q[2];
    wire avg_cmp = cfg_q[1];
    wire pol_high = cfg_q[0];
    wire [3:0] cfg_wr = I_WR_DATA[15:12];

    // a result loads only on its completed update
    wire shunt_load = I_SHUNT_UPD && I_AVG_DONE;
    wire bus_load = I_BUS_UPD && I_AVG_DONE;
    wire temp_load = I_TEMP_UPD && I_AVG_DONE;
    wire calc_load = I_CALC_UPD && I_AVG_DONE;
    wire fault_now = avg_cmp ? (I_FAULT_AVG && I_AVG_DONE) : I_FAULT_RAW;
    wire conv_done = I_AVG_DONE;

    // Shunt voltage holding register
    mrar_result
    #(
        .W(SHUNT_W)
    )
    u_shunt
    (
        .I_REF_CLK(I_REF_CLK),
        .I_RESETN(I_RESETN),
        .i_load(shunt_load),
        .i_value(I_SHUNT_VAL),
        .o_value(shunt_q)
    );

    // Bus voltage holding register
    mrar_result
    #(
        .W(BUS_W)
    )
    u_bus
    (
        .I_REF_CLK(I_REF_CLK),
        .I_RESETN(I_RESETN),
        .i_load(bus_load),
        .i_value(I_BUS_VAL),
        .o_value(bus_q)
    );

    // Die temperature holding register
    mrar_result
    #(
        .W(TEMP_W)
    )
    u_temp
    (
        .I_REF_CLK(I_REF_CLK),
        .I_RESETN(I_RESETN),
        .i_load(temp_load),
        .i_value(I_TEMP_VAL),
        .o_value(temp_q)
    );

    // Current holding register
    mrar_result
    #(
        .W(CURR_W)
    )
    u_curr
    (
        .I_REF_CLK(I_REF_CLK),
        .I_RESETN(I_RESETN),
        .i_load(calc_load),
        .i_value(I_CURR_VAL),
        .o_value(curr_q)
    );

    // Power holding register
    mrar_result
    #(
        .W(POWER_W)
    )
    u_power
    (
        .I_REF_CLK(I_REF_CLK),
        .I_RESETN(I_RESETN),
        .i_load(calc_load),
        .i_value(I_POWER_VAL),
        .o_value(power_q)
    );

    // Alert pin readback synchroniser
    mrar_sync
    u_pin
    (
        .I_REF_CLK(I_REF_CLK),
        .I_RESETN(I_RESETN),
        .i_async(I_ALERT_PIN),
        .o_level(alert_level)
    );

    wire ovf_set = I_CALC_UPD && I_MATH_OVF;
    wire ovf_clr = I_CONV_START;

    // Overflow: set wins, cleared only by a new conversion
    always_comb
    begin
        ovf_d = ovf_q;
        if (ovf_clr)
            ovf_d = 1'b0;
        if (ovf_set)
            ovf_d = 1'b1;
    end

    wire done_clr_latched = latch_en && (diag_read || I_CONV_START);
    wire done_clr_open = !latch_en && I_CONV_START;

    // Done flag: set wins over any clear
    always_comb
    begin
        done_d = done_q;
        if (conv_done)
        begin
            done_d = 1'b1;
        end
        else if (done_clr_latched)
        begin
            done_d = 1'b0;
        end
        else if (done_clr_open)
        begin
            done_d = 1'b0;
        end
    end

    wire fault_gone = !fault_now;
    wire held_release = diag_read && fault_gone;
    wire held_drop = !latch_en && fault_gone;

    // Alert state machine
    always_comb
    begin
        alert_d = alert_q;
        unique case (alert_q)
            MRAR_A_IDLE:
            begin
                if (fault_now)
                    alert_d = latch_en ? MRAR_A_HELD : MRAR_A_ACTIVE;
            end
            MRAR_A_ACTIVE:
            begin
                if (latch_en)
                    alert_d = MRAR_A_HELD;
                else if (fault_gone)
                    alert_d = MRAR_A_IDLE;
            end
            MRAR_A_HELD:
            begin
                if (held_release)
                    alert_d = MRAR_A_IDLE;
                else if (held_drop)
                    alert_d = MRAR_A_IDLE;
            end
            default:
            begin
                alert_d = MRAR_A_IDLE;
            end
        endcase
    end

    wire alert_flag = (alert_q != MRAR_A_IDLE);
    wire alert_active = alert_flag || (ready_alert && done_q);
    wire alert_drive_low = pol_high ? !alert_active : alert_active;
    assign cfg_d = diag_write ? cfg_wr : cfg_q;
    wire rd_valid_d = I_RD_STB;

    // Read words with reserved bits at zero
    wire [23:0] shunt_word = pad_word(shunt_q);
    wire [23:0] bus_word = pad_word(bus_q);
    wire [23:0] temp_word = pad_word({temp_q, 4'h0});
    wire [23:0] curr_word = pad_word(curr_q);
    wire [23:0] power_word = power_q;
    wire [23:0] diag_word = pad_word({cfg_q, 2'b00, ovf_q, 7'h00, done_q, I_MEM_OK});

    assign rd_data_d =
        ({24{sel_shunt}} & shunt_word) |
        ({24{sel_bus}} & bus_word) |
        ({24{sel_temp}} & temp_word) |
        ({24{sel_curr}} & curr_word) |
        ({24{sel_power}} & power_word) |
        ({24{sel_diag}} & diag_word);

    // Registers
    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            cfg_q <= DIAG_RESET[15:12];
        else
            cfg_q <= cfg_d;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            ovf_q <= DIAG_RESET[OVF_BIT];
        else
            ovf_q <= ovf_d;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            done_q <= DIAG_RESET[DONE_BIT];
        else
            done_q <= done_d;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            alert_q <= MRAR_A_IDLE;
        else
            alert_q <= alert_d;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            O_RD_VALID <= 1'b0;
        else
            O_RD_VALID <= rd_valid_d;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            O_RD_DATA <= POWER_RESET;
        else if (I_RD_STB)
            O_RD_DATA <= rd_data_d;
    end

    // Open-drain: the output enable pulls the pin low
    assign O_ALERT_OUT = 1'b0;
    assign O_ALERT_OE = alert_drive_low;
    assign O_ALERT_LEVEL = alert_level;
endmodule

// ### core/mrar_pkg.sv
// Package with register map, field positions and reset values for the result/alert bank
package mrar_pkg;
    localparam logic [7:0] ADDR_SHUNT = 8'h04;
    localparam logic [7:0] ADDR_BUS = 8'h05;
    localparam logic [7:0] ADDR_TEMP = 8'h06;
    localparam logic [7:0] ADDR_CURR = 8'h07;
    localparam logic [7:0] ADDR_POWER = 8'h08;
    localparam logic [7:0] ADDR_DIAG = 8'h0b;
    localparam logic [15:0] DIAG_RESET = 16'h0001;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [23:0] POWER_RESET = 24'h000000;
    localparam int LATCH_BIT = 15;
    localparam int READY_ALERT_BIT = 14;
    localparam int AVG_CMP_BIT = 13;
    localparam int POL_BIT = 12;
    localparam int OVF_BIT = 9;
    localparam int DONE_BIT = 1;
    localparam int MEM_BIT = 0;
    localparam int TEMP_LSB = 4;
    localparam logic [3:0] CFG_WRITE_MASK_SHIFT = 4'hc;
    typedef enum logic [1:0]
    {
        MRAR_A_IDLE = 2'b00,
        MRAR_A_ACTIVE = 2'b01,
        MRAR_A_HELD = 2'b10
    } mrar_alert_t;
endpackage

// ### core/mrar_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mrar_sync
(
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic i_async,
    output logic o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            // Pulled-up idle level of the pin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            o_level <= 1'b1;
        end
        else
        begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                o_level <= s3_q;
        end
    end
endmodule

// ### core/mrar_result.sv
// Holding register for one result word, loaded only on a completed update
`timescale 1ns/1ps
module mrar_result #(parameter int W = 16)
(
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic i_load,
    input wire logic [W-1:0] i_value,
    output logic [W-1:0] o_value
);
    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            o_value <= '0;
        else if (i_load)
            o_value <= i_value;
    end
endmodule

// ### bench/mrar_host.sv
// Host model issuing register reads and configuration writes
`timescale 1ns/1ps
module mrar_host
(
    input wire logic i_clk,
    output logic [7:0] o_rd_addr = 8'h00,
    output logic o_rd_stb = 1'b0,
    output logic o_wr_stb = 1'b0,
    output logic [15:0] o_wr_data = 16'h0000
);
    // Address and data go to their inverse once released
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk) #1;
        {o_rd_addr, o_rd_stb} = {a, 1'b1};
        @(posedge i_clk) #1;
        {o_rd_addr, o_rd_stb} = {~a, 1'b0};
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge i_clk) #1;
        {o_wr_data, o_wr_stb} = {d, 1'b1};
        @(posedge i_clk) #1;
        {o_wr_data, o_wr_stb} = {~d, 1'b0};
    endtask
endmodule

// ### bench/mrar_props.sv
// Checker of read timing, reserved bits and alert behaviour
`timescale 1ns/1ps
module mrar_props
    import mrar_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic [7:0] I_RD_ADDR,
    input wire logic I_RD_STB,
    input wire logic [23:0] O_RD_DATA,
    input wire logic O_RD_VALID,
    input wire logic I_WR_STB,
    input wire logic [15:0] I_WR_DATA,
    input wire logic I_CONV_START,
    input wire logic I_CALC_UPD,
    input wire logic I_AVG_DONE,
    input wire logic I_MATH_OVF,
    input wire logic I_SHUNT_UPD,
    input wire logic [15:0] I_SHUNT_VAL,
    input wire logic I_FAULT_RAW,
    input wire logic O_ALERT_OUT,
    input wire logic O_ALERT_OE
);
    logic [3:0] cfg_q;
    logic ovf_q;
    logic [15:0] shunt_q;
    wire logic rd_diag = I_RD_STB && I_RD_ADDR == ADDR_DIAG;
    wire logic quiet = !I_WR_STB && !I_FAULT_RAW;
    always_ff @(posedge I_REF_CLK or negedge I_RESETN)
        if (!I_RESETN)
            {cfg_q, ovf_q, shunt_q} <= '0;
        else
        begin
            cfg_q <= I_WR_STB ? I_WR_DATA[15:12] : cfg_q;
            ovf_q <= (I_CALC_UPD && I_MATH_OVF) || (ovf_q && !I_CONV_START);
            shunt_q <= (I_SHUNT_UPD && I_AVG_DONE) ? I_SHUNT_VAL : shunt_q;
        end
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);
    sequence diag_read; rd_diag; endsequence
    sequence latch_held; cfg_q == 4'h8 && O_ALERT_OE && !I_WR_STB && !rd_diag; endsequence
    rd_valid_a: assert property (I_RD_STB |=> O_RD_VALID) else $error("no read valid");
    valid_pulse_a: assert property (!I_RD_STB |=> !O_RD_VALID) else $error("stray valid");
    temp_resv_a: assert property (I_RD_STB && I_RD_ADDR == ADDR_TEMP |=> O_RD_DATA[3:0] == 4'h0)
        else $error("temp low bits set");
    diag_resv_a: assert property (diag_read |=> O_RD_DATA[11:10] == 2'h0 && O_RD_DATA[23:16] == 8'h00
        && O_RD_DATA[15:12] == $past(cfg_q)) else $error("diag bits wrong");
    ovf_flag_a: assert property (diag_read |=> O_RD_DATA[9] == $past(ovf_q))
        else $error("overflow flag wrong");
    shunt_hold_a: assert property (I_RD_STB && I_RD_ADDR == ADDR_SHUNT
        |=> O_RD_DATA[15:0] == $past(shunt_q)) else $error("shunt value wrong");
    latch_hold_a: assert property (latch_held ##0 !$past(rd_diag) |=> O_ALERT_OE)
        else $error("latched alert dropped");
    raw_alert_a: assert property (cfg_q == 4'h0 && I_FAULT_RAW && !I_WR_STB |=> O_ALERT_OE)
        else $error("alert missing");
    raw_idle_a: assert property (cfg_q == 4'h0 && quiet |=> !O_ALERT_OE) else $error("alert stuck");
    pol_idle_a: assert property (cfg_q == 4'h1 && quiet |=> O_ALERT_OE) else $error("polarity");
    slow_cmp_a: assert property (cfg_q == 4'h2 && !I_AVG_DONE && !I_WR_STB && !O_ALERT_OE
        |=> !O_ALERT_OE) else $error("raw fault alerted");
    od_low_a: assert property (O_ALERT_OUT == 1'b0) else $error("pin driven high");
endmodule
bind mrar_top mrar_props u_props (.*);

// ### bench/mrar_top_test.sv
// Self-checking bench for the result and diagnostic/alert register bank
`timescale 1ns/1ps
module mrar_top_test;
    import mrar_pkg::*;
    logic I_REF_CLK = 1'b0, I_RESETN = 1'b0, I_SAMPLE_DONE = 1'b0, I_MEM_OK = 1'b1;
    logic I_CONV_START = 1'b0, I_AVG_DONE = 1'b0, I_SHUNT_UPD = 1'b0, I_BUS_UPD = 1'b0;
    logic I_TEMP_UPD = 1'b0, I_CALC_UPD = 1'b0, I_MATH_OVF = 1'b0;
    logic I_FAULT_RAW = 1'b0, I_FAULT_AVG = 1'b0, O_RD_VALID, O_ALERT_OUT, O_ALERT_OE, O_ALERT_LEVEL;
    logic [15:0] I_SHUNT_VAL = '0, I_BUS_VAL = '0, I_CURR_VAL = '0;
    logic [11:0] I_TEMP_VAL = '0;
    logic [23:0] I_POWER_VAL = '0, O_RD_DATA;
    wire logic [7:0] I_RD_ADDR;
    wire logic [15:0] I_WR_DATA;
    wire logic I_RD_STB, I_WR_STB;
    wire logic I_ALERT_PIN = ~O_ALERT_OE;
    logic [31:0] rs = 32'h0000004c, ent, q[$];
    int n_mismatch = 0, comparisons = 0;
    always #5 I_REF_CLK = ~I_REF_CLK;
    mrar_top dut (.*);
    mrar_host host (.i_clk(I_REF_CLK), .o_rd_addr(I_RD_ADDR), .o_rd_stb(I_RD_STB),
        .o_wr_stb(I_WR_STB), .o_wr_data(I_WR_DATA));
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge I_REF_CLK);
        #1;
    endtask
    task automatic pulse(input logic [5:0] p);
        {I_CONV_START, I_AVG_DONE, I_SHUNT_UPD, I_BUS_UPD, I_TEMP_UPD, I_CALC_UPD} = p;
        step(1);
        {I_CONV_START, I_AVG_DONE, I_SHUNT_UPD, I_BUS_UPD, I_TEMP_UPD, I_CALC_UPD} = 6'h00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        q.push_back({a, e});
        host.rd(a);
    endtask
    task automatic oe(input logic e);
        cmp("alert_oe", {23'h0, e}, {23'h0, O_ALERT_OE});
    endtask
    task automatic rd_all();
        rd(ADDR_SHUNT, {8'h00, I_SHUNT_VAL});
        rd(ADDR_BUS, {8'h00, I_BUS_VAL});
        rd(ADDR_TEMP, {8'h00, I_TEMP_VAL, 4'h0});
        rd(ADDR_CURR, {8'h00, I_CURR_VAL});
        rd(ADDR_POWER, I_POWER_VAL);
    endtask
    task automatic flip();
        {I_SHUNT_VAL, I_BUS_VAL, I_CURR_VAL} = ~{I_SHUNT_VAL, I_BUS_VAL, I_CURR_VAL};
        {I_TEMP_VAL, I_POWER_VAL} = ~{I_TEMP_VAL, I_POWER_VAL};
    endtask
    always @(negedge I_REF_CLK)
        if (O_RD_VALID === 1'b1)
        begin
            ent = q.pop_front();
            cmp($sformatf("reg %h", ent[31:24]), ent[23:0], O_RD_DATA);
        end
    initial
    begin
        step(16);
        I_RESETN = 1'b1;
        for (int a = 4; a <= 12; a++)
            rd(a[7:0], a == 11 ? 24'h000001 : 24'h000000);
        cmp("alert_level", 24'h000001, {23'h0, O_ALERT_LEVEL});
        $display("reset values done");
        repeat (2)
        begin
            {I_SHUNT_VAL, I_BUS_VAL} = xs();
            {I_CURR_VAL, I_TEMP_VAL, I_POWER_VAL} = 52'({xs(), xs()});
            pulse(6'h1f);
            rd_all();
            flip();
            pulse(6'h0f);
            flip();
            rd_all();
        end
        $display("result loads done");
        I_MATH_OVF = 1'b1;
        pulse(6'h11);
        I_MATH_OVF = 1'b0;
        rd(ADDR_DIAG, 24'h000203);
        pulse(6'h20);
        rd(ADDR_DIAG, 24'h000001);
        $display("overflow flag done");
        I_FAULT_RAW = 1'b1;
        step(2);
        oe(1'b1);
        I_FAULT_RAW = 1'b0;
        step(2);
        oe(1'b0);
        host.wr(16'h8000);
        I_FAULT_RAW = 1'b1;
        step(1);
        I_FAULT_RAW = 1'b0;
        step(3);
        oe(1'b1);
        step(2);
        cmp("alert_level", 24'h000000, {23'h0, O_ALERT_LEVEL});
        rd(ADDR_DIAG, 24'h008001);
        step(2);
        oe(1'b0);
        host.wr(16'h4000);
        pulse(6'h10);
        step(2);
        oe(1'b1);
        pulse(6'h20);
        step(2);
        oe(1'b0);
        host.wr(16'h1000);
        step(2);
        oe(1'b1);
        I_FAULT_RAW = 1'b1;
        step(2);
        oe(1'b0);
        host.wr(16'h2000);
        step(3);
        oe(1'b0);
        I_FAULT_AVG = 1'b1;
        pulse(6'h10);
        oe(1'b1);
        {I_FAULT_AVG, I_FAULT_RAW} = 2'b00;
        pulse(6'h10);
        host.wr(16'h0000);
        step(3);
        cmp("pending reads", 24'h0, 24'(q.size()));
        $display("alert modes done");
        tally_and_finish();
    end
    initial
    begin
        step(20000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
